// File: core/wpc_cfg.svh
// Purpose: Offsets, field positions, reset values and key code of the
//          write protect control block
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes:   Definitions only
`ifndef WPC_CFG_SVH
`define WPC_CFG_SVH

// Register byte offsets
`define WPC_CTRL_OFS     8'h00
`define WPC_STAT_OFS     8'h04
// Key code demanded in the upper byte of a control write
`define WPC_KEY          8'hA5
// Byte enables of one aligned 16-bit write to the low halfword
`define WPC_SEL_HALF     4'h3
// Control field positions
`define WPC_BIT_CLK      0
`define WPC_BIT_MODE     1
`define WPC_CTRL_RST     2'h0
// Status field positions (sticky, write 1 to clear)
`define WPC_STAT_BADKEY  0
`define WPC_STAT_CLKBLK  1
`define WPC_STAT_MODEBLK 2
`define WPC_STAT_RST     3'h0

`endif

// File: core/wpc_pkg.sv
// Purpose: Types shared by the write protect control files
// Assumes: Constants live in wpc_cfg.svh
// Notes:   Nothing here is imported; users write wpc_pkg::name
package wpc_pkg;

    // Which register a bus address selects
    typedef enum logic [1:0] {
        REG_CTRL = 2'b00,
        REG_STAT = 2'b01,
        REG_NONE = 2'b10
    } reg_sel_type;

    // Two protect enables held by the control register
    typedef struct packed {
        logic mode_power_regs_write_enable;
        logic clock_regs_write_enable;
    } protect_bits_type;

endpackage : wpc_pkg

// File: core/wpc_key_if.sv
// Purpose: Carries a candidate control write to the key checker
// Assumes: Same clock on both ends; verdict is combinational
// Notes:   accept and reject are only meaningful while valid is high
`timescale 1ns/1ps
interface wpc_key_if;
    logic        valid;   // Control write being committed
    logic [15:0] data;    // Low halfword of write data
    logic [3:0]  sel;     // Byte enables of the write
    logic        accept;  // Key and width are right
    logic        reject;  // Write must be dropped

    // Register side offers the write
    modport regs (output valid, output data, output sel,
                  input accept, input reject);
    // Checker side judges it
    modport check (input valid, input data, input sel,
                   output accept, output reject);
endinterface : wpc_key_if

// File: core/wpc_key_check.sv
// Purpose: Judges whether a control write may change the protect bits
// Assumes: Low halfword sits in data bits 15:0
// Notes:   Pure combinational verdict
`timescale 1ns/1ps
`include "wpc_cfg.svh"
module wpc_key_check (
    wpc_key_if.check key_if
);
    logic width_ok;   // Exactly the low two byte lanes
    logic key_ok;     // Upper byte carries the key

    // Verdict on width and key
    always_comb begin
        width_ok      = (key_if.sel == `WPC_SEL_HALF);
        key_ok        = (key_if.data[15:8] == `WPC_KEY);
        key_if.accept = key_if.valid && width_ok && key_ok;
        key_if.reject = key_if.valid && !(width_ok && key_ok);
    end
endmodule : wpc_key_check

// File: core/register_write_protect_control.sv
// Purpose: Write protect control register with key-guarded update,
//          reached over classic Wishbone, gating protected writes
// Assumes: 40 MHz clk_i, synchronous active-high rst_i, ce_i freezes
// Notes:   Answer one cycle after a request; unmapped address gives err
//          Status at 0x04 flags refused writes and blocked attempts
//
// What this block does
// - Control update needs one full 16-bit write
// - Bit 0 gates clock generation register writes
// - Bit 1 gates mode, power, reset writes
// - Bit 2 reads zero, software writes zero
// - Upper byte must be A5h to update
// - Bits 7 to 4 read zero
`timescale 1ns/1ps
`include "wpc_cfg.svh"
module register_write_protect_control #(
    parameter int ADDR_W = 8            // Bus address width
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Classic Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    output logic                   err_o,
    // Protected register write requests from the system bus
    input  wire logic              clk_grp_wr_i,
    input  wire logic              mode_grp_wr_i,
    // Granted protected writes, one cycle later
    output logic                   clk_grp_wr_ok_o,
    output logic                   mode_grp_wr_ok_o,
    // Protect enables as levels
    output logic                   clock_regs_write_enable_o,
    output logic                   mode_power_regs_write_enable_o
);

    // Address decode, used by answer and read paths
    // Only the two exact offsets hit; anything else answers err
    function automatic wpc_pkg::reg_sel_type decode_addr(
        input logic [ADDR_W-1:0] adr);
        if (adr == ADDR_W'(`WPC_CTRL_OFS)) begin
            return wpc_pkg::REG_CTRL;
        end else if (adr == ADDR_W'(`WPC_STAT_OFS)) begin
            return wpc_pkg::REG_STAT;
        end else begin
            return wpc_pkg::REG_NONE;
        end
    endfunction : decode_addr

    wpc_pkg::protect_bits_type ctrl_ff;      // Protect enables
    logic [2:0]                stat_ff;      // Sticky status bits
    logic                      ack_ff;       // Answer, good address
    logic                      err_ff;       // Answer, unmapped address
    logic [31:0]               rdata_ff;     // Read data
    logic                      clk_ok_ff;    // Clock group grant
    logic                      mode_ok_ff;   // Mode group grant
    logic                      req;          // Live bus request
    logic                      answered;     // Answer already out
    wpc_pkg::reg_sel_type      hit;          // Decoded register
    logic                      commit;       // Write takes effect now
    logic                      ctrl_commit;  // Control write commits
    logic                      stat_commit;  // Status write commits
    logic [2:0]                stat_set;     // Events this cycle
    logic [2:0]                stat_clr;     // Clears this cycle
    logic [2:0]                nxt_stat;     // Next status value
    logic [31:0]               nxt_rdata;    // Next read data

    wpc_key_if key_if ();                    // Link to key checker

    // Key and width checker
    wpc_key_check u_key_check (
        .key_if (key_if)
    );

    // Request and decode
    // answered stops a held request from being taken again in the cycle of its answer
    always_comb begin
        req      = cyc_i && stb_i;
        answered = ack_ff || err_ff;
        hit      = decode_addr(adr_i);
    end

    // Writes commit on the edge where the master sees ack
    // One effect per answer; a master holding stb past ack commits again every other cycle
    always_comb begin
        commit      = ce_i && req && we_i && ack_ff;
        ctrl_commit = commit && (hit == wpc_pkg::REG_CTRL);
        stat_commit = commit && (hit == wpc_pkg::REG_STAT);
    end

    // Offer control writes to the checker
    // The key sits in bits 15:8 and the value in bits 7:0
    always_comb begin
        key_if.valid = ctrl_commit;
        key_if.data  = dat_i[15:0];
        key_if.sel   = sel_i;
    end

    // Answer: ack or err one cycle after the request, for one cycle
    // A master that holds stb past the answer sees a new answer every second cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Idle bus after reset
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (ce_i) begin
            // Mapped address answers with ack
            ack_ff <= req && !answered && (hit != wpc_pkg::REG_NONE);
            // Unmapped address answers with err
            err_ff <= req && !answered && (hit == wpc_pkg::REG_NONE);
        end
    end

    // Read data mux, reserved bits as zero
    // Reserved control bits are forced low here, never stored
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (hit)
            wpc_pkg::REG_CTRL: begin
                // Key byte and bits 7:2 read zero
                nxt_rdata[`WPC_BIT_CLK]  = ctrl_ff.clock_regs_write_enable;
                nxt_rdata[`WPC_BIT_MODE] = ctrl_ff.mode_power_regs_write_enable;
            end
            wpc_pkg::REG_STAT: begin
                // Sticky status in low bits
                nxt_rdata[2:0] = stat_ff;
            end
            default: begin
                // Unmapped reads zero
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data register, loaded with the answer
    // Loaded when taken, so dat_o stands steady while ack stands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Nothing to show after reset
            rdata_ff <= 32'h0000_0000;
        end else if (ce_i && req && !answered) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Protect enables: only a keyed 16-bit write changes them
    // No ce_i term needed here: accept already carries it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `WPC_CTRL_RST;
        end else if (key_if.accept) begin
            // Low byte bits 1:0 stored, others dropped
            // Reserved bits are never stored, so they cannot read back
            ctrl_ff.clock_regs_write_enable      <= dat_i[`WPC_BIT_CLK];
            ctrl_ff.mode_power_regs_write_enable <= dat_i[`WPC_BIT_MODE];
        end
    end

    // Protected write gating, registered grant
    // Grant follows the bits as they stood before this edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // No grants while in reset
            clk_ok_ff  <= 1'b0;
            mode_ok_ff <= 1'b0;
        end else if (ce_i) begin
            // Clock generation group
            clk_ok_ff  <= clk_grp_wr_i && ctrl_ff.clock_regs_write_enable;
            // Mode, power and reset group
            mode_ok_ff <= mode_grp_wr_i && ctrl_ff.mode_power_regs_write_enable;
        end
    end

    // Status events and clears; set wins over clear
    // An event and a clear in one cycle leave the flag set
    always_comb begin
        stat_set = 3'h0;
        stat_clr = 3'h0;
        stat_set[`WPC_STAT_BADKEY]  = key_if.reject;
        stat_set[`WPC_STAT_CLKBLK]  = ce_i && clk_grp_wr_i
                                      && !ctrl_ff.clock_regs_write_enable;
        stat_set[`WPC_STAT_MODEBLK] = ce_i && mode_grp_wr_i
                                      && !ctrl_ff.mode_power_regs_write_enable;
        // Write 1 to clear, low lane only
        if (stat_commit && sel_i[0]) begin
            stat_clr = dat_i[2:0];
        end
        nxt_stat = (stat_ff & ~stat_clr) | stat_set;
    end

    // Sticky status register
    // Frozen with the rest of the state while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Nothing flagged after reset
            stat_ff <= `WPC_STAT_RST;
        end else if (ce_i) begin
            stat_ff <= nxt_stat;
        end
    end

    // Outputs straight from flip-flops
    // Registered levels, so the protected groups never see a glitch
    always_comb begin
        ack_o                          = ack_ff;
        err_o                          = err_ff;
        dat_o                          = rdata_ff;
        clk_grp_wr_ok_o                = clk_ok_ff;
        mode_grp_wr_ok_o               = mode_ok_ff;
        clock_regs_write_enable_o      = ctrl_ff.clock_regs_write_enable;
        mode_power_regs_write_enable_o = ctrl_ff.mode_power_regs_write_enable;
    end

    // Checks, sampled on clk_i and idle while rst_i is high
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Remembered control read answers
    // Lets the reserved-bit checks look only at control reads
    logic ctrl_rd_q;   // Answer belongs to a control read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_rd_q <= 1'b0;
        end else if (ce_i && req && !answered) begin
            ctrl_rd_q <= !we_i && (hit == wpc_pkg::REG_CTRL);
        end
    end

    a_half_word_only: assert property (
        ctrl_commit && (sel_i != `WPC_SEL_HALF) |=> $stable(ctrl_ff))
        else $error("Narrow control write changed protect bits");

    a_key_gate: assert property (
        ctrl_commit && (dat_i[15:8] != `WPC_KEY) |=> $stable(ctrl_ff))
        else $error("Control changed without key");

    a_key_update: assert property (
        ctrl_commit && (sel_i == `WPC_SEL_HALF) && (dat_i[15:8] == `WPC_KEY)
        |=> ctrl_ff == $past(dat_i[1:0]))
        else $error("Keyed control write not stored");

    a_clock_grant: assert property (
        ce_i ##1 ce_i |-> clk_grp_wr_ok_o
            == ($past(clk_grp_wr_i) && $past(ctrl_ff.clock_regs_write_enable)))
        else $error("Clock group grant wrong");

    a_mode_grant: assert property (
        ce_i ##1 ce_i |-> mode_grp_wr_ok_o
            == ($past(mode_grp_wr_i) && $past(ctrl_ff.mode_power_regs_write_enable)))
        else $error("Mode group grant wrong");

    a_rsvd_bit2: assert property (
        ack_o && ctrl_rd_q |-> dat_o[2] == 1'b0)
        else $error("Reserved bit 2 read nonzero");

    a_rsvd_high: assert property (
        ack_o && ctrl_rd_q |-> dat_o[31:4] == 28'h0000000 && dat_o[3] == 1'b0)
        else $error("Reserved control bits read nonzero");

    a_reset_clear: assert property (
        $past(rst_i) |-> ctrl_ff == `WPC_CTRL_RST && !clk_grp_wr_ok_o)
        else $error("Protect bits not clear after reset");

    a_narrow_write_flag: assert property (
        ctrl_commit && (sel_i != `WPC_SEL_HALF)
        |=> stat_ff[`WPC_STAT_BADKEY])
        else $error("Narrow control write not flagged");

    a_bad_key_flag: assert property (
        ctrl_commit && (dat_i[15:8] != `WPC_KEY)
        |=> stat_ff[`WPC_STAT_BADKEY])
        else $error("Control write without key not flagged");

    a_clk_block_flag: assert property (
        ce_i && clk_grp_wr_i && !ctrl_ff.clock_regs_write_enable
        |=> stat_ff[`WPC_STAT_CLKBLK] && !clk_grp_wr_ok_o)
        else $error("Blocked clock group write not flagged");

    a_mode_block_flag: assert property (
        ce_i && mode_grp_wr_i && !ctrl_ff.mode_power_regs_write_enable
        |=> stat_ff[`WPC_STAT_MODEBLK] && !mode_grp_wr_ok_o)
        else $error("Blocked mode group write not flagged");

    a_freeze_hold: assert property (
        !ce_i |=> $stable(ctrl_ff) && $stable(stat_ff) && $stable(clk_grp_wr_ok_o))
        else $error("State moved while clock enable low");

    // Main scenarios reached
    c_keyed_write: cover property (key_if.accept);
    c_bad_key: cover property (key_if.reject ##1 stat_ff[`WPC_STAT_BADKEY]);
    c_clk_blocked: cover property (ce_i && clk_grp_wr_i
                                   && !ctrl_ff.clock_regs_write_enable);
    c_unmapped: cover property (err_o);
    c_frozen: cover property (!ce_i && clk_grp_wr_i);

endmodule : register_write_protect_control

// File: sim/tb_register_write_protect_control.sv
// Purpose: Self-checking bench for the write protect control block
// Assumes: Classic Wishbone master in this bench, 40 MHz clock, ce_i high except in the freeze test
// Notes:   Seeded random control writes mixed with corner cases
`timescale 1ns/1ps
`include "wpc_cfg.svh"
module tb_register_write_protect_control;
    logic        clk_i;          // System clock
    logic        rst_i;          // Synchronous reset
    logic        ce_i;           // Clock enable, low only in the freeze test
    logic        cyc_i;          // Bus cycle
    logic        stb_i;          // Bus strobe
    logic        we_i;           // Write direction
    logic [7:0]  adr_i;          // Byte address
    logic [3:0]  sel_i;          // Byte enables
    logic [31:0] dat_i;          // Write data
    logic [31:0] dat_o;          // Read data
    logic        ack_o;          // Normal answer
    logic        err_o;          // Unmapped answer
    logic        clk_grp_wr_i;   // Clock group write attempt
    logic        mode_grp_wr_i;  // Mode group write attempt
    logic        clk_grp_wr_ok_o;
    logic        mode_grp_wr_ok_o;
    logic        clock_regs_write_enable_o;
    logic        mode_power_regs_write_enable_o;
    int          n_fail;         // Mismatch count
    int          total_checks;   // Comparison count
    integer      seed;           // Random seed
    logic [1:0]  exp_ctrl;       // Expected protect bits
    logic [31:0] rd;             // Last read data
    logic        er;             // Last error answer
    logic [3:0]  s;              // Random byte enables
    logic [31:0] d;              // Random write data

    register_write_protect_control #(.ADDR_W(8)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .clk_grp_wr_i(clk_grp_wr_i),
        .mode_grp_wr_i(mode_grp_wr_i), .clk_grp_wr_ok_o(clk_grp_wr_ok_o),
        .mode_grp_wr_ok_o(mode_grp_wr_ok_o),
        .clock_regs_write_enable_o(clock_regs_write_enable_o),
        .mode_power_regs_write_enable_o(mode_power_regs_write_enable_o));

    // Free-running 25 ns clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Compare one value and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // One classic single cycle, held until ack or err is sampled at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] bs,
                      input logic [31:0] wd, output logic [31:0] q, output logic e);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= bs;
        dat_i <= wd;
        // No cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1 && err_o !== 1'b1);
        // Answer edge: data and response taken here, then release
        q = dat_o;
        e = err_o;
        chk(ack_o & err_o, 1'b0, "ack and err together");
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    // Expected control after a write: only full halfword with key lands
    function automatic logic [1:0] model(logic [1:0] cur, logic [3:0] bs, logic [31:0] wd);
        return (bs == `WPC_SEL_HALF && wd[15:8] == `WPC_KEY) ? wd[1:0] : cur;
    endfunction : model

    // Read control back and compare bits, reserved zeros and levels
    task automatic rd_ctrl();
        wb(1'b0, `WPC_CTRL_OFS, 4'hF, 32'h0, rd, er);
        chk(rd, {30'h0, exp_ctrl}, "control read");
        chk(clock_regs_write_enable_o, exp_ctrl[0], "clock enable level");
        chk(mode_power_regs_write_enable_o, exp_ctrl[1], "mode enable level");
    endtask : rd_ctrl

    // Random group write attempts, grant seen one cycle later
    task automatic gate();
        logic a;
        logic b;
        a = $random(seed);
        b = $random(seed);
        @(posedge clk_i);
        clk_grp_wr_i  <= a;
        mode_grp_wr_i <= b;
        @(posedge clk_i);
        clk_grp_wr_i  <= 1'b0;
        mode_grp_wr_i <= 1'b0;
        // Grant launched at the last edge still stands at this one
        @(posedge clk_i);
        chk(clk_grp_wr_ok_o, a & exp_ctrl[0], "clock group grant");
        chk(mode_grp_wr_ok_o, b & exp_ctrl[1], "mode group grant");
    endtask : gate

    // Write then verify against the model
    task automatic wr_ctrl(input logic [3:0] bs, input logic [31:0] wd);
        wb(1'b1, `WPC_CTRL_OFS, bs, wd, rd, er);
        exp_ctrl = model(exp_ctrl, bs, wd);
        rd_ctrl();
        gate();
    endtask : wr_ctrl

    // Hang guard sized well past the planned traffic
    initial begin
        #(25.0 * 20000);
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        seed          = 32'h5DAB3EE7;
        n_fail        = 0;
        total_checks  = 0;
        exp_ctrl      = 2'h0;
        rst_i         = 1'b1;
        ce_i          = 1'b1;
        cyc_i         = 1'b0;
        stb_i         = 1'b0;
        we_i          = 1'b0;
        adr_i         = 8'h00;
        sel_i         = 4'h0;
        dat_i         = 32'h0;
        clk_grp_wr_i  = 1'b0;
        mode_grp_wr_i = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_ctrl();
        gate();
        wr_ctrl(4'h3, 32'h0000A5FF);
        wr_ctrl(4'h3, 32'h00005A00);
        wb(1'b0, `WPC_STAT_OFS, 4'hF, 32'h0, rd, er);
        chk(rd[0], 1'b1, "bad key flagged");
        // Write 1 to clear every status flag, then read them back as zero
        wb(1'b1, `WPC_STAT_OFS, 4'h1, 32'h0000_0007, rd, er);
        wb(1'b0, `WPC_STAT_OFS, 4'hF, 32'h0, rd, er);
        chk(rd, 32'h0, "status cleared");
        wr_ctrl(4'hF, 32'h0000A500);
        wr_ctrl(4'h1, 32'h0000A500);
        wr_ctrl(4'h3, 32'h0000A501);
        wr_ctrl(4'h3, 32'h0000A502);
        wb(1'b0, 8'h40, 4'hF, 32'h0, rd, er);
        chk(er, 1'b1, "unmapped gives err");
        chk(rd, 32'h0, "unmapped data zero");
        for (int i = 0; i < 40; i++) begin
            s = ($random(seed) & 1) ? 4'h3 : 4'(($random(seed) & 1) ? 4'hF : 4'h1);
            d = $random(seed);
            if ($random(seed) & 1) d[15:8] = 8'hA5;
            wr_ctrl(s, d);
        end
        wr_ctrl(4'h3, 32'h0000A503);
        // Clock enable low: grants must not follow attempts while frozen
        @(posedge clk_i);
        ce_i          <= 1'b0;
        clk_grp_wr_i  <= 1'b1;
        mode_grp_wr_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(clk_grp_wr_ok_o, 1'b0, "clock grant frozen");
        chk(mode_grp_wr_ok_o, 1'b0, "mode grant frozen");
        ce_i          <= 1'b1;
        clk_grp_wr_i  <= 1'b0;
        mode_grp_wr_i <= 1'b0;
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        exp_ctrl = 2'h0;
        rd_ctrl();
        gate();
        report_and_stop();
    end
endmodule : tb_register_write_protect_control
